//--- hdl/sio_pkg.sv
// Constants, register map and carrier types for the scheme I/O indication block
// Overview of operation
// - One filter bit per opto-input; one applies half-cycle filter, zero bypasses it.
// - One characteristic setting for all inputs; default 80% pick-up, 60% drop-off.
// - Global nominal voltage setting; custom exposes a per-input voltage range.
// - Each output relay conditioner can latch, delay pick-up or delay drop-off.
// - Programmable layer has eight-input gates and delay or conditioning timers.
// - Programmable logic re-evaluates every gate when any input changed or a gate mask was written.
// - Four groups keep reference, download time and identifier: ten cells each.
// - Trip indicator lights on trip, holds until fault record cleared unless self-reset.
// - Alarm indicator flashes while unacknowledged, steady once accepted, off when cleared.
// - Out-of-service indicator is on while protection is unavailable.
// - Healthy indicator on while unit works, off on self-test error.
// - Watchdog contacts follow the healthy indicator at all times.
// - Trip indicator resets by front-panel clear or by a reset logic input.
// - A system function link bit enables trip indicator self-reset when one.
// - Self-reset clears trip after pole-dead low three seconds with start inactive.
// - Start active after breaker closes inhibits automatic trip indicator reset.
package sio_pkg;
  localparam int unsigned N_OPTO     = 8;
  localparam int unsigned N_RELAY    = 8;
  localparam int unsigned N_GROUPS   = 4;
  localparam int unsigned REF_CHARS  = 32;
  localparam int unsigned CLK_MHZ    = 200;
  localparam int unsigned QUAL_S     = 3;
  localparam int unsigned QUAL_CYC   = QUAL_S * CLK_MHZ * 1000000;
  localparam int unsigned FLASH_MS   = 500;
  localparam int unsigned FLASH_CYC  = FLASH_MS * CLK_MHZ * 1000;
  localparam int unsigned HALF_MS    = 10;
  localparam int unsigned FILT_CYC   = HALF_MS * CLK_MHZ * 1000;
  localparam int unsigned RLY_DLY_CYC = 1000000;

  // Register byte offsets
  localparam logic [11:0] A_CTRL     = 12'h000;
  localparam logic [11:0] A_FILTER   = 12'h004;
  localparam logic [11:0] A_OPTOCFG  = 12'h008;
  localparam logic [11:0] A_OPTOIN   = 12'h00C;
  localparam logic [11:0] A_RLYMODE  = 12'h010;
  localparam logic [11:0] A_RLYDLY   = 12'h014;
  localparam logic [11:0] A_GATEAND  = 12'h018;
  localparam logic [11:0] A_GATEOR   = 12'h01C;
  localparam logic [11:0] A_STATUS   = 12'h020;
  localparam logic [11:0] A_IRQSTAT  = 12'h024;
  localparam logic [11:0] A_IRQMASK  = 12'h028;
  localparam logic [11:0] A_OPTOV    = 12'h02C;
  localparam logic [11:0] A_VER_BASE = 12'h100;
  // Version block: per group 8 ref words, 1 time, 1 id -> stride 0x40
  localparam int unsigned VER_STRIDE_SH = 6;
  localparam int unsigned VER_TIME_W    = 8;
  localparam int unsigned VER_ID_W      = 9;

  // Control bit positions
  localparam int unsigned C_SELFRST  = 0;
  localparam int unsigned C_CLRTRIP  = 1;
  localparam int unsigned C_ACKALM   = 2;
  localparam int unsigned C_CLRALM   = 3;
  localparam int unsigned C_CHAR_LSB = 4;
  localparam int unsigned C_NOM_LSB  = 8;

  localparam logic [1:0] CHAR_80_60 = 2'h0;
  localparam logic [2:0] NOM_CUSTOM = 3'h7;
  localparam logic [31:0] FILTER_RST = 32'hFFFF_FFFF;

  typedef enum logic [1:0] {
    SIO_RLY_DIRECT = 2'h0,
    SIO_RLY_LATCH  = 2'h1,
    SIO_RLY_PICKUP = 2'h2,
    SIO_RLY_DROP   = 2'h3
  } sio_rly_mode_t;

  typedef enum logic [2:0] {
    SIO_ALM_OFF    = 3'b001,
    SIO_ALM_FLASH  = 3'b010,
    SIO_ALM_STEADY = 3'b100
  } sio_alm_state_t;

  // Interrupt bits
  localparam int unsigned I_TRIP  = 0;
  localparam int unsigned I_ALARM = 1;
  localparam int unsigned I_UNHL  = 2;
  localparam int unsigned I_OPTO  = 3;

  typedef struct packed {
    logic trip;
    logic alarm_new;
    logic start;
    logic pole_dead;
    logic cb_closed;
    logic prot_unavail;
    logic selftest_err;
    logic clear_key;
    logic reset_input;
  } sio_plant_t;

  typedef struct packed {
    logic trip;
    logic alarm;
    logic oos;
    logic healthy;
  } sio_led_t;
endpackage : sio_pkg

//--- hdl/sio_top.sv
// Opto conditioning, relay conditioners, fixed indicators and APB registers
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module sio_top #(
  parameter int unsigned QUAL_CYCLES  = sio_pkg::QUAL_CYC,
  parameter int unsigned FLASH_CYCLES = sio_pkg::FLASH_CYC,
  parameter int unsigned FILT_CYCLES  = sio_pkg::FILT_CYC,
  parameter int unsigned RLY_CYCLES   = sio_pkg::RLY_DLY_CYC
) (
  // Clock, reset, enable
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         clk_en,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Plant and panel
  input  wire logic [sio_pkg::N_OPTO-1:0]   opto_in,
  input  wire sio_pkg::sio_plant_t          plant,
  // Outputs
  output logic [sio_pkg::N_RELAY-1:0]       relay_out,
  output sio_pkg::sio_led_t                 led,
  output logic                              watchdog,
  output logic                              irq
);
  import sio_pkg::*;

  localparam int unsigned NV = N_GROUPS * (8 + 2);

  typedef struct packed {
    logic [N_OPTO-1:0]   s1, s2, s3;
    logic [N_OPTO-1:0]   opto;
    logic [N_OPTO-1:0]   opto_prev;
    logic [N_OPTO-1:0][31:0] fcnt;
    logic [31:0]         ctrl;
    logic [31:0]         filter;
    logic [31:0]         optov;
    logic [15:0]         rly_mode;
    logic [31:0]         rly_dly;
    logic [N_RELAY-1:0][N_OPTO-1:0] gand;
    logic [N_RELAY-1:0][N_OPTO-1:0] gor;
    logic [N_RELAY-1:0]  gate_q;
    logic                recalc;
    logic [N_RELAY-1:0]  rly;
    logic [N_RELAY-1:0][31:0] rcnt;
    logic [8:0]          pl1, pl2, pl3;
    logic [8:0]          pl_acc;
    logic                trip_led;
    sio_alm_state_t      alm;
    logic [31:0]         fcount;
    logic                blink;
    logic                alarm_led;
    logic [31:0]         qcount;
    logic                reclosed;
    logic                inhibit;
    logic [3:0]          ist;
    logic [3:0]          imask;
    logic                led_oos, led_ok, wd;
    logic                irq;
    logic [31:0]         rdata;
    logic                ready, slverr;
  } sio_state_t;

  sio_state_t q, d;
  logic [31:0] ver_mem [NV];
  sio_plant_t  pl;
  logic        wr_acc, rd_acc;
  logic [31:0] rd_mux;
  logic        rd_ok;
  logic [5:0]  vidx;
  logic [3:0]  vslot;

  assign wr_acc = psel & penable & pwrite & ~q.ready;
  assign rd_acc = psel & penable & ~pwrite & ~q.ready;
  assign vslot  = paddr[5:2];
  assign vidx   = 6'(paddr[7:6] * 10 + vslot);

  // Version records: reference words, time, identifier per group
  always_ff @(posedge pclk) begin
    if (clk_en && wr_acc && paddr[11:8] == A_VER_BASE[11:8] && vslot < 4'd10) begin
      ver_mem[vidx] <= pwdata;
    end
  end

  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr[11:8] == A_VER_BASE[11:8]) begin
      rd_ok = (vslot < 4'd10);
      if (rd_ok) begin
        rd_mux = ver_mem[vidx];
      end
    end else begin
      unique case (paddr)
        A_CTRL:    rd_mux = q.ctrl;
        A_FILTER:  rd_mux = q.filter;
        A_OPTOCFG: rd_mux = {29'h0, q.ctrl[C_NOM_LSB+:3]};
        A_OPTOIN:  rd_mux = 32'(q.opto);
        A_RLYMODE: rd_mux = {16'h0, q.rly_mode};
        A_RLYDLY:  rd_mux = q.rly_dly;
        A_GATEAND: rd_mux = 32'(q.gand[0]);
        A_GATEOR:  rd_mux = 32'(q.gor[0]);
        A_STATUS:  rd_mux = {24'h0, q.rly[3:0], q.trip_led, q.alm == SIO_ALM_FLASH,
                             q.led_oos, q.led_ok};
        A_IRQSTAT: rd_mux = {28'h0, q.ist};
        A_IRQMASK: rd_mux = {28'h0, q.imask};
        A_OPTOV:   rd_mux = q.optov;
        default:   rd_ok  = 1'b0;
      endcase
    end
  end

  always_comb begin
    logic [3:0] ev;
    logic       clr_trip;
    logic       any_rly_cfg;
    d  = q;
    ev = 4'h0;
    any_rly_cfg = 1'b0;
    clr_trip = 1'b0;
    pl = sio_plant_t'(q.pl_acc);
    // Three-stage pin sampling; change counts when stages 2 and 3 agree
    d.s1 = opto_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.pl1 = plant;
    d.pl2 = q.pl1;
    d.pl3 = q.pl2;
    // First stage feeds only the second; accept once stages 2 and 3 agree
    if (q.pl2 == q.pl3) begin
      d.pl_acc = q.pl3;
    end
    for (int i = 0; i < N_OPTO; i++) begin
      if (q.s2[i] != q.s3[i] || q.s3[i] == q.opto[i]) begin
        d.fcnt[i] = 32'h0000_0000;
      end else if (!q.filter[i]) begin
        d.opto[i] = q.s3[i];
      end else if (q.fcnt[i] >= FILT_CYCLES - 1) begin
        d.opto[i] = q.s3[i];
        d.fcnt[i] = 32'h0000_0000;
      end else begin
        d.fcnt[i] = q.fcnt[i] + 32'h0000_0001;
      end
    end
    d.opto_prev = q.opto;
    if (q.opto != q.opto_prev) begin
      ev[I_OPTO] = 1'b1;
    end
    // Gates: AND over selected inputs, OR over selected inputs; recomputed on change
    for (int r = 0; r < N_RELAY; r++) begin
      if (q.opto != q.opto_prev || q.recalc) begin
        d.gate_q[r] = (((q.opto & q.gand[r]) == q.gand[r]) && q.gand[r] != '0)
                      || |(q.opto & q.gor[r]);
      end
    end
    // Relay conditioners
    for (int r = 0; r < N_RELAY; r++) begin
      unique case (sio_rly_mode_t'(q.rly_mode[2*r+:2]))
        SIO_RLY_DIRECT: d.rly[r] = q.gate_q[r];
        SIO_RLY_LATCH:  d.rly[r] = q.rly[r] | q.gate_q[r];
        SIO_RLY_PICKUP, SIO_RLY_DROP: begin
          if (q.gate_q[r] == q.rly[r]) begin
            d.rcnt[r] = 32'h0000_0000;
          end else if ((q.gate_q[r] ^ (q.rly_mode[2*r+:2] == SIO_RLY_PICKUP))
                       || q.rcnt[r] >= q.rly_dly) begin
            d.rly[r]  = q.gate_q[r];
            d.rcnt[r] = 32'h0000_0000;
          end else begin
            d.rcnt[r] = q.rcnt[r] + 32'h0000_0001;
          end
        end
      endcase
    end
    // Flash tick
    if (q.fcount >= FLASH_CYCLES - 1) begin
      d.fcount = 32'h0000_0000;
      d.blink  = ~q.blink;
    end else begin
      d.fcount = q.fcount + 32'h0000_0001;
    end
    // Trip indicator
    clr_trip = pl.clear_key | pl.reset_input | q.ctrl[C_CLRTRIP];
    if (!pl.cb_closed) begin
      d.reclosed = 1'b0;
      d.inhibit  = 1'b0;
    end else begin
      d.reclosed = q.trip_led;
      // Inhibit lasts only while start stands; qualifier restarts after it
      d.inhibit  = pl.start;
    end
    if (q.ctrl[C_SELFRST] && q.reclosed && !pl.pole_dead && !pl.start && !q.inhibit) begin
      d.qcount = q.qcount + 32'h0000_0001;
    end else begin
      d.qcount = 32'h0000_0000;
    end
    if (pl.trip) begin
      d.trip_led = 1'b1;
      if (!q.trip_led) begin
        ev[I_TRIP] = 1'b1;
      end
    end else if (clr_trip) begin
      d.trip_led = 1'b0;
    end else if (q.qcount >= QUAL_CYCLES - 1 && q.ctrl[C_SELFRST]) begin
      d.trip_led = 1'b0;
      d.qcount   = 32'h0000_0000;
    end
    // Alarm indicator
    unique case (q.alm)
      SIO_ALM_OFF: begin
        if (pl.alarm_new) begin
          d.alm = SIO_ALM_FLASH;
          ev[I_ALARM] = 1'b1;
        end
      end
      SIO_ALM_FLASH: begin
        if (q.ctrl[C_CLRALM]) begin
          d.alm = SIO_ALM_OFF;
        end else if (q.ctrl[C_ACKALM] && !pl.alarm_new) begin
          d.alm = SIO_ALM_STEADY;
        end
      end
      SIO_ALM_STEADY: begin
        if (pl.alarm_new) begin
          d.alm = SIO_ALM_FLASH;
          ev[I_ALARM] = 1'b1;
        end else if (q.ctrl[C_CLRALM]) begin
          d.alm = SIO_ALM_OFF;
        end
      end
      default: d.alm = SIO_ALM_OFF;
    endcase
    // Registered so the pin carries no gate after the flop
    d.alarm_led = (d.alm == SIO_ALM_STEADY) | ((d.alm == SIO_ALM_FLASH) & d.blink);
    d.ctrl[C_CLRTRIP] = 1'b0;
    d.ctrl[C_ACKALM]  = 1'b0;
    d.ctrl[C_CLRALM]  = 1'b0;
    d.led_oos = pl.prot_unavail;
    d.led_ok  = ~pl.selftest_err;
    d.wd      = ~pl.selftest_err;
    if (q.led_ok && pl.selftest_err) begin
      ev[I_UNHL] = 1'b1;
    end
    // APB slave, one wait state
    d.ready  = 1'b0;
    d.slverr = 1'b0;
    if (psel && penable && !q.ready) begin
      d.ready  = 1'b1;
      d.slverr = ~rd_ok;
      d.rdata  = pwrite ? 32'h0000_0000 : rd_mux;
      if (rd_acc && paddr == A_IRQSTAT) begin
        d.ist = 4'h0;
      end
      if (wr_acc) begin
        unique case (paddr)
          A_CTRL:    d.ctrl = pwdata;
          A_FILTER:  d.filter = pwdata;
          A_OPTOV:   d.optov = pwdata;
          A_RLYMODE: d.rly_mode = pwdata[15:0];
          A_RLYDLY:  d.rly_dly = pwdata;
          A_GATEAND: d.gand = {N_RELAY{pwdata[N_OPTO-1:0]}};
          A_GATEOR:  d.gor  = {N_RELAY{pwdata[N_OPTO-1:0]}};
          A_IRQMASK: d.imask = pwdata[3:0];
          default: ;
        endcase
        if (paddr == A_OPTOCFG) begin
          d.ctrl[C_NOM_LSB+:3] = pwdata[2:0];
        end
        any_rly_cfg = (paddr == A_GATEAND || paddr == A_GATEOR);
      end
    end
    // New gate masks: re-evaluate next cycle even without an input change
    d.recalc = any_rly_cfg;
    d.ist = d.ist | ev; // set wins over read clear
    d.irq = |(d.ist & q.imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q        <= '0;
      q.filter <= FILTER_RST;
      q.alm    <= SIO_ALM_OFF;
      q.rly_dly <= RLY_CYCLES;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign prdata      = q.rdata;
  assign pready      = q.ready;
  assign pslverr     = q.slverr;
  assign relay_out   = q.rly;
  assign led.trip    = q.trip_led;
  assign led.alarm   = q.alarm_led;
  assign led.oos     = q.led_oos;
  assign led.healthy = q.led_ok;
  assign watchdog    = q.wd;
  assign irq         = q.irq;
endmodule : sio_top

//--- tb/sio_monitor.sv
// Port checker for the scheme I/O indication block
`timescale 1ns/1ps
module sio_monitor
  import sio_pkg::*;
(
  // Clock and reset
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        clk_en,
  // APB
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [11:0]                 paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  // Plant and outputs
  input wire logic [sio_pkg::N_OPTO-1:0]  opto_in,
  input wire sio_pkg::sio_plant_t         plant,
  input wire logic [sio_pkg::N_RELAY-1:0] relay_out,
  input wire sio_pkg::sio_led_t           led,
  input wire logic                        watchdog,
  input wire logic                        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wd; watchdog == led.healthy; endproperty
  a_wd: assert property (p_wd) else $error("watchdog differs from healthy");
  property p_ack; psel && penable && !pready |=> pready; endproperty
  a_ack: assert property (p_ack) else $error("no answer after one wait state");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("pready longer than one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  // Six cycles cover the three-stage sampler, accept stage and output flop
  property p_oos_on; (plant.prot_unavail && clk_en)[*6] |-> led.oos; endproperty
  a_oos_on: assert property (p_oos_on) else $error("oos not lit");
  property p_oos_off; (!plant.prot_unavail && clk_en)[*6] |-> !led.oos; endproperty
  a_oos_off: assert property (p_oos_off) else $error("oos lit");
  property p_hl; (plant.selftest_err && clk_en)[*6] |-> !led.healthy; endproperty
  a_hl: assert property (p_hl) else $error("healthy lit on error");
  property p_trip; (plant.trip && clk_en)[*6] |-> led.trip; endproperty
  a_trip: assert property (p_trip) else $error("trip led not lit");
  sequence s_quiet; plant.start && !plant.clear_key && !plant.reset_input && !psel; endsequence
  property p_inh; s_quiet[*8] ##0 led.trip |=> led.trip; endproperty
  a_inh: assert property (p_inh) else $error("trip led reset while start active");
  c_trip_clr: cover property (led.trip ##1 !led.trip);
  c_refused: cover property (pslverr);
  c_irq: cover property ($rose(irq));
endmodule : sio_monitor

bind sio_top sio_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .opto_in(opto_in), .plant(plant), .relay_out(relay_out),
  .led(led), .watchdog(watchdog), .irq(irq));

//--- tb/sio_plant_model.sv
// Breaker and protection-start model facing the plant inputs
`timescale 1ns/1ps
module sio_plant_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Scenario controls
  input  wire logic fault,
  input  wire logic slow,
  input  wire logic hold_start,
  // Breaker side levels
  output logic      trip,
  output logic      start,
  output logic      pole_dead,
  output logic      cb_closed
);
  int cnt_q;
  // Slow breaker stretches the dead time before reclose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 0;
    else if (cnt_q == 0) cnt_q <= fault ? 1 : 0;
    else if (cnt_q >= (slow ? 48 : 18)) cnt_q <= 0;
    else cnt_q <= cnt_q + 1;
  end
  assign trip = cnt_q inside {[1:8]};
  assign start = trip || (cnt_q == 0 && hold_start);
  assign pole_dead = cnt_q > 8;
  assign cb_closed = !pole_dead;
endmodule : sio_plant_model

//--- tb/testbench.sv
// Self-checking bench for the scheme I/O indication block
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin check_count++; if ((sn) !== (ex)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, ex, sn); end end
module testbench;
  import sio_pkg::*;
  localparam int unsigned QC = 50;
  localparam int unsigned FC = 8;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, watchdog, irq;
  logic fault, slow, hold, am, pu, se, ck, ri, mt, ms, mp, mc, err, s0, s1;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [N_OPTO-1:0] opto_in;
  logic [N_RELAY-1:0] ro;
  sio_plant_t        plant;
  sio_led_t          led;
  logic [31:0]       sh [int];
  int                failures, check_count;
  assign plant = '{trip: mt, alarm_new: am, start: ms, pole_dead: mp, cb_closed: mc,
    prot_unavail: pu, selftest_err: se, clear_key: ck, reset_input: ri};
  sio_top #(.QUAL_CYCLES(QC), .FLASH_CYCLES(FC), .FILT_CYCLES(4), .RLY_CYCLES(10)) uut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .opto_in(opto_in), .plant(plant), .relay_out(ro), .led(led),
    .watchdog(watchdog), .irq(irq));
  sio_plant_model u_plant (.pclk(pclk), .presetn(presetn), .fault(fault), .slow(slow),
    .hold_start(hold), .trip(mt), .start(ms), .pole_dead(mp), .cb_closed(mc));
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task automatic stop_test();
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // Request held until pready is sampled, then released for one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      failures++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    sh[a] = d;
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK($sformatf("reg %h", a), e, rd)
  endtask : rchk
  task automatic trip_event();
    fault <= 1'b1;
    tick(1);
    fault <= 1'b0;
    tick(12);
    `CHK("trip led on", 1'b1, led.trip)
  endtask : trip_event
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    {presetn, clk_en, psel, penable, pwrite, fault, slow, hold} = 8'h40;
    {am, pu, se, ck, ri} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    opto_in = '0;
    failures = 0;
    check_count = 0;
    void'($urandom(32'h5540));
    tick(6);
    presetn <= 1'b1;
    tick(1);
    apb(1'b0, A_CTRL, 32'h0000_0000);
    `CHK("characteristic", CHAR_80_60, rd[5:4])
    rchk(A_FILTER, FILTER_RST);
    apb(1'b1, A_CTRL, 32'h0000_0700);
    rchk(A_OPTOCFG, 32'h0000_0007);
    wr(A_FILTER, $urandom);
    wr(A_OPTOV, $urandom);
    for (int g = 0; g < N_GROUPS; g++) begin
      for (int w = 0; w < 10; w++) begin
        wr(A_VER_BASE + 12'(g * 64 + w * 4), $urandom);
      end
    end
    foreach (sh[a]) rchk(12'(a), sh[a]);
    opto_in <= N_OPTO'($urandom);
    tick(30);
    rchk(A_OPTOIN, 32'(opto_in));
    // Relays 0..3: direct, latch, pick-up delay, drop-off delay, all OR of input 0
    opto_in <= '0;
    tick(12);
    apb(1'b1, A_FILTER, 32'h0000_0000);
    apb(1'b1, A_RLYMODE, 32'h0000_00E4);
    apb(1'b1, A_GATEAND, 32'h0000_0000);
    apb(1'b1, A_GATEOR, 32'h0000_0001);
    tick(4);
    `CHK("relays idle", 4'b0000, ro[3:0])
    opto_in <= N_OPTO'(1);
    tick(8);
    `CHK("relays picked", 4'b1011, ro[3:0])
    tick(12);
    `CHK("pick-up delay", 4'b1111, ro[3:0])
    opto_in <= '0;
    tick(8);
    `CHK("relays dropped", 4'b1010, ro[3:0])
    tick(12);
    `CHK("drop-off delay", 4'b0010, ro[3:0])
    apb(1'b1, 12'h800, $urandom);
    `CHK("refused write", 1'b1, err)
    apb(1'b0, 12'h800, 32'h0000_0000);
    `CHK("refused read", 32'h0000_0000, rd)
    `CHK("refused read error", 1'b1, err)
    `CHK("healthy on", 1'b1, led.healthy)
    se <= 1'b1;
    tick(8);
    `CHK("healthy off", 1'b0, led.healthy)
    `CHK("watchdog off", 1'b0, watchdog)
    se <= 1'b0;
    pu <= 1'b1;
    tick(8);
    `CHK("oos on", 1'b1, led.oos)
    pu <= 1'b0;
    tick(8);
    `CHK("oos off", 1'b0, led.oos)
    trip_event();
    tick(QC + 40);
    `CHK("no self reset", 1'b1, led.trip)
    ck <= 1'b1;
    tick(8);
    ck <= 1'b0;
    tick(2);
    `CHK("clear key", 1'b0, led.trip)
    trip_event();
    tick(20);
    ri <= 1'b1;
    tick(8);
    ri <= 1'b0;
    tick(2);
    `CHK("reset input", 1'b0, led.trip)
    apb(1'b1, A_CTRL, 32'h0000_0701);
    hold <= 1'b1;
    slow <= 1'b1;
    trip_event();
    tick(2 * QC);
    `CHK("start inhibits", 1'b1, led.trip)
    hold <= 1'b0;
    tick(QC / 2);
    `CHK("qualifier running", 1'b1, led.trip)
    tick(QC / 2 + 10);
    `CHK("self reset", 1'b0, led.trip)
    apb(1'b1, A_IRQMASK, 32'h0000_0000);
    apb(1'b0, A_IRQSTAT, 32'h0000_0000);
    // Level must outlast the input sampler to be accepted
    am <= 1'b1;
    tick(4);
    am <= 1'b0;
    tick(8);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, A_IRQMASK, 32'h0000_000F);
    tick(2);
    `CHK("irq unmasked", 1'b1, irq)
    apb(1'b0, A_IRQSTAT, 32'h0000_0000);
    `CHK("irq status", 1'b1, rd[I_ALARM])
    tick(2);
    `CHK("irq cleared", 1'b0, irq)
    s0 = 1'b0;
    s1 = 1'b0;
    repeat (4 * FC) begin
      tick(1);
      s0 |= ~led.alarm;
      s1 |= led.alarm;
    end
    `CHK("alarm flash", 1'b1, s0 & s1)
    apb(1'b1, A_CTRL, 32'h0000_0705);
    tick(8);
    s0 = 1'b0;
    repeat (2 * FC) begin
      tick(1);
      s0 |= ~led.alarm;
    end
    `CHK("alarm steady", 1'b0, s0)
    apb(1'b1, A_CTRL, 32'h0000_0709);
    tick(8);
    `CHK("alarm off", 1'b0, led.alarm)
    stop_test();
  end
endmodule : testbench
